// ==== logic/tmr2_timer.sv ====
// 16-bit capture / auto-reload timer behind a byte register port
// assumes one 50 MHz clock MCLK, async active-high RESET, pins asynchronous
// assumes the core never raises the write and read strobes in one cycle
//
// How it works
// (R1) with counter_timer_select at 0 the count advances once every two clocks.
// (R2) with counter_timer_select at 1 the count advances on each falling edge of the count pin.
// (R3) with capture_reload_select at 0 overflow and an enabled trigger edge reload the count.
// (R4) with capture_reload_select at 1 an enabled trigger edge copies the count into the reload value.
// (R5) when either serial clock select picks this timer, overflow always reloads and capture is off.
// (R6) the reload/capture value lives at CAh (low) and CBh (high), resetting to 00h.
// (R7) the running count is read and written at CCh (low) and CDh (high), resetting to 00h.
// (R8) overflow sets overflow_flag unless a serial clock select is on; software clears it.
// (R9) an enabled trigger edge that captures or reloads sets external_trigger_flag; software clears it.
// (R10) trigger edges act only with trigger_enable set and both serial clock selects clear.
// (R11) overflow is given out as serial receive/transmit bit clock when its select bit is 1.
// (R12) the count advances and overflows only while run_control is set.
`timescale 1ns/100ps
`include "tmr2_defines.svh"

module tmr2_timer
   import tmr2_pkg::*;
(
   // clock and reset
   input  wire logic       MCLK,
   input  wire logic       RESET,
   // register port
   input  wire logic [7:0] ADDR,
   input  wire logic [7:0] WDATA,
   input  wire logic       WR,
   input  wire logic       RD,
   output logic      [7:0] RDATA,
   // pins
   input  wire logic       COUNT_INPUT_PIN,
   input  wire logic       EXTERNAL_TRIGGER_PIN,
   // serial bit clocks, one pulse per overflow
   output logic            SERIAL_RX_TICK,
   output logic            SERIAL_TX_TICK
);

   tmr2_state_t st_r;
   tmr2_state_t st_nxt;

   // filtered pin level changes once the last two sync stages agree
   // a pin glitch shorter than one clock never reaches the count
   function automatic logic filt(input logic [2:0] s, input logic cur);
      filt = (s[1] == s[2]) ? s[2] : cur;
   endfunction

   // ----------------------------------------------------------------------
   // next-state logic
   // ----------------------------------------------------------------------
   always_comb begin
      logic        cnt_fall;
      logic        trg_fall;
      logic        serial_use;
      logic        tick;
      logic        ovf;
      logic        trg_act;
      logic [16:0] sum;
      // locals start defined on every pass
      cnt_fall   = 1'b0;
      trg_fall   = 1'b0;
      serial_use = 1'b0;
      tick       = 1'b0;
      ovf        = 1'b0;
      trg_act    = 1'b0;
      sum        = 17'h00000;
      st_nxt = st_r;
      // three-flop synchronisers and the agreement filter per pin
      st_nxt.cnt_pin_sync_r = {st_r.cnt_pin_sync_r[1:0], COUNT_INPUT_PIN};
      st_nxt.trg_pin_sync_r = {st_r.trg_pin_sync_r[1:0], EXTERNAL_TRIGGER_PIN};
      st_nxt.cnt_pin_state_r = filt(st_r.cnt_pin_sync_r, st_r.cnt_pin_state_r);
      st_nxt.trg_pin_state_r = filt(st_r.trg_pin_sync_r, st_r.trg_pin_state_r);
      // falling edges of the filtered levels
      cnt_fall = st_r.cnt_pin_state_r & ~st_nxt.cnt_pin_state_r;
      trg_fall = st_r.trg_pin_state_r & ~st_nxt.trg_pin_state_r;
      // serial use overrides capture and gates the trigger pin
      serial_use = st_r.ctrl_r[`TMR2_BIT_RXCLK] | st_r.ctrl_r[`TMR2_BIT_TXCLK];
      // prescaler toggles always so timer ticks stay on a fixed phase
      st_nxt.prescale_r = ~st_r.prescale_r;
      tick = st_r.ctrl_r[`TMR2_BIT_CNT_SEL] ? cnt_fall                        // see (R2)
                                            : (st_r.prescale_r == `TMR2_TICK_CYCLES); // see (R1)
      tick = tick & st_r.ctrl_r[`TMR2_BIT_RUN];                               // see (R12)
      // carry out of the 16-bit add marks an overflow
      sum = {1'b0, st_r.count_r} + 17'h00001;
      ovf = tick & sum[16];
      trg_act = trg_fall & st_r.ctrl_r[`TMR2_BIT_TRIG_EN] & ~serial_use;      // see (R10)
      // count path: tick first, the reloads below override it
      if (tick) begin
         st_nxt.count_r = sum[15:0];
      end
      // reload on overflow, forced when a serial select is on
      if (ovf & (serial_use | ~st_r.ctrl_r[`TMR2_BIT_CAP_SEL])) begin        // see (R3) see (R5)
         st_nxt.count_r = st_r.reload_r;
      end
      if (trg_act & ~st_r.ctrl_r[`TMR2_BIT_CAP_SEL]) begin                   // see (R3)
         st_nxt.count_r = st_r.reload_r;
      end
      // software writes land first so hardware set wins on the flags
      if (WR) begin
         case (ADDR)
            `TMR2_ADDR_CONTROL:   st_nxt.ctrl_r = WDATA;
            `TMR2_ADDR_RELOAD_LO: st_nxt.reload_r[7:0] = WDATA;               // see (R6)
            `TMR2_ADDR_RELOAD_HI: st_nxt.reload_r[15:8] = WDATA;              // see (R6)
            `TMR2_ADDR_COUNT_LO:  st_nxt.count_r[7:0] = WDATA;                // see (R7)
            `TMR2_ADDR_COUNT_HI:  st_nxt.count_r[15:8] = WDATA;               // see (R7)
            default: ;
         endcase
      end
      if (trg_act & st_r.ctrl_r[`TMR2_BIT_CAP_SEL]) begin                    // see (R4)
         st_nxt.reload_r = st_r.count_r;
      end
      if (ovf & ~serial_use) begin
         st_nxt.ctrl_r[`TMR2_BIT_OVF] = 1'b1;                                 // see (R8)
      end
      if (trg_act) begin
         st_nxt.ctrl_r[`TMR2_BIT_EXTF] = 1'b1;                                // see (R9)
      end
      // ticks last one cycle, one per overflow
      st_nxt.rx_tick_r = ovf & st_r.ctrl_r[`TMR2_BIT_RXCLK];                  // see (R11)
      st_nxt.tx_tick_r = ovf & st_r.ctrl_r[`TMR2_BIT_TXCLK];                  // see (R11)
      // read data valid only in the cycle after the strobe
      // unmapped reads return 00h so a stray address reads as empty
      st_nxt.rdata_r = `TMR2_RST_BYTE;
      if (RD) begin
         case (ADDR)
            `TMR2_ADDR_CONTROL:   st_nxt.rdata_r = st_r.ctrl_r;
            `TMR2_ADDR_RELOAD_LO: st_nxt.rdata_r = st_r.reload_r[7:0];
            `TMR2_ADDR_RELOAD_HI: st_nxt.rdata_r = st_r.reload_r[15:8];
            `TMR2_ADDR_COUNT_LO:  st_nxt.rdata_r = st_r.count_r[7:0];
            `TMR2_ADDR_COUNT_HI:  st_nxt.rdata_r = st_r.count_r[15:8];
            default:              st_nxt.rdata_r = `TMR2_RST_BYTE;
         endcase
      end
   end

   // ----------------------------------------------------------------------
   // state register
   // ----------------------------------------------------------------------
   // one register holds the whole state; reset clears every field
   always_ff @(posedge MCLK or posedge RESET) begin
      if (RESET) begin
         st_r <= '0;
      end else begin
         st_r <= st_nxt;
      end
   end

   // ----------------------------------------------------------------------
   // outputs
   // ----------------------------------------------------------------------
   // every output is a field of the state register
   assign RDATA          = st_r.rdata_r;
   assign SERIAL_RX_TICK = st_r.rx_tick_r;
   assign SERIAL_TX_TICK = st_r.tx_tick_r;

   // ----------------------------------------------------------------------
   // assertions
   // ----------------------------------------------------------------------
   // serial use as seen by the checks
   wire logic srl = st_r.ctrl_r[`TMR2_BIT_RXCLK] | st_r.ctrl_r[`TMR2_BIT_TXCLK];

   // checks look at the registered state one edge after the cause
   a_timer_stopped: assert property (@(posedge MCLK) disable iff (RESET) // see (R12)
      (!st_r.ctrl_r[`TMR2_BIT_RUN] && !WR && !$past(WR) && st_r.ctrl_r[`TMR2_BIT_CAP_SEL])
      |=> st_r.count_r == $past(st_r.count_r) || $past(st_r.reload_r) != st_r.reload_r)
      else $error("count moved while stopped");

   a_timer_rate: assert property (@(posedge MCLK) disable iff (RESET) // see (R1)
      (st_r.ctrl_r[2:1] == 2'b10 && !WR && st_r.count_r != 16'hFFFF && !st_r.prescale_r
       && !st_r.ctrl_r[`TMR2_BIT_TRIG_EN])
      |=> st_r.count_r == $past(st_r.count_r))
      else $error("timer advanced on off phase");

   a_reload_ovf: assert property (@(posedge MCLK) disable iff (RESET) // see (R3)
      (st_r.ctrl_r[`TMR2_BIT_RUN] && !st_r.ctrl_r[1] && st_r.prescale_r && st_r.count_r == 16'hFFFF
       && !st_r.ctrl_r[0] && !WR) |=> st_r.count_r == $past(st_r.reload_r))
      else $error("no reload on overflow");

   a_forced_reload: assert property (@(posedge MCLK) disable iff (RESET) // see (R5)
      (st_r.ctrl_r[2:1] == 2'b10 && st_r.prescale_r && st_r.count_r == 16'hFFFF && srl && !WR)
      |=> st_r.count_r == $past(st_r.reload_r))
      else $error("serial use did not force reload");

   a_ovf_flag: assert property (@(posedge MCLK) disable iff (RESET) // see (R8)
      (st_r.ctrl_r[2:1] == 2'b10 && st_r.prescale_r && st_r.count_r == 16'hFFFF && !srl)
      |=> st_r.ctrl_r[`TMR2_BIT_OVF])
      else $error("overflow flag not set");

   a_flag_sticky: assert property (@(posedge MCLK) disable iff (RESET) // see (R8)
      (st_r.ctrl_r[`TMR2_BIT_OVF] && !WR) |=> st_r.ctrl_r[`TMR2_BIT_OVF])
      else $error("overflow flag dropped without a write");

   a_tick_out: assert property (@(posedge MCLK) disable iff (RESET) // see (R11)
      SERIAL_TX_TICK |-> $past(st_r.ctrl_r[`TMR2_BIT_TXCLK]) && $past(st_r.count_r) == 16'hFFFF)
      else $error("tx tick without overflow");

   a_rx_tick_out: assert property (@(posedge MCLK) disable iff (RESET) // see (R11)
      SERIAL_RX_TICK |-> $past(st_r.ctrl_r[`TMR2_BIT_RXCLK]) && $past(st_r.count_r) == 16'hFFFF)
      else $error("rx tick without overflow");

   a_trig_gate: assert property (@(posedge MCLK) disable iff (RESET) // see (R10)
      ($rose(st_r.ctrl_r[`TMR2_BIT_EXTF]) && !$past(WR)) |-> $past(st_r.ctrl_r[`TMR2_BIT_TRIG_EN]) && !$past(srl))
      else $error("trigger acted while gated");

   a_trig_capture: assert property (@(posedge MCLK) disable iff (RESET) // see (R4)
      ($rose(st_r.ctrl_r[`TMR2_BIT_EXTF]) && !$past(WR) && $past(st_r.ctrl_r[`TMR2_BIT_CAP_SEL]))
      |-> st_r.reload_r == $past(st_r.count_r))
      else $error("capture did not copy the count");

   a_trig_reload: assert property (@(posedge MCLK) disable iff (RESET) // see (R3)
      ($rose(st_r.ctrl_r[`TMR2_BIT_EXTF]) && !$past(WR) && !$past(st_r.ctrl_r[`TMR2_BIT_CAP_SEL]))
      |-> st_r.count_r == $past(st_r.reload_r))
      else $error("trigger did not reload the count");

   a_read_data: assert property (@(posedge MCLK) disable iff (RESET) // see (R7)
      (RD && ADDR == `TMR2_ADDR_COUNT_HI) |=> RDATA == $past(st_r.count_r[15:8]))
      else $error("count high read mismatch");

   a_reload_read: assert property (@(posedge MCLK) disable iff (RESET) // see (R6)
      (WR && ADDR == `TMR2_ADDR_RELOAD_LO) ##1 (RD && ADDR == `TMR2_ADDR_RELOAD_LO && !st_r.ctrl_r[0])
      |=> RDATA == $past(WDATA, 2))
      else $error("reload low readback mismatch");

   // main scenarios the bench should reach
   c_overflow: cover property (@(posedge MCLK) disable iff (RESET) st_r.ctrl_r[`TMR2_BIT_OVF]);
   c_capture: cover property (@(posedge MCLK) disable iff (RESET)
      st_r.ctrl_r[`TMR2_BIT_EXTF] && st_r.ctrl_r[`TMR2_BIT_CAP_SEL]);
   c_serial: cover property (@(posedge MCLK) disable iff (RESET) SERIAL_RX_TICK);
   c_trig_reload: cover property (@(posedge MCLK) disable iff (RESET)
      st_r.ctrl_r[`TMR2_BIT_EXTF] && !st_r.ctrl_r[`TMR2_BIT_CAP_SEL]);
   c_counter_mode: cover property (@(posedge MCLK) disable iff (RESET)
      st_r.ctrl_r[`TMR2_BIT_CNT_SEL] && st_r.count_r != 16'h0000);

endmodule

// ==== logic/tmr2_defines.svh ====
// register offsets, field positions, reset values and timing counts of the
// capture/reload timer; included by the design and the bench
`ifndef TMR2_DEFINES_SVH
`define TMR2_DEFINES_SVH
// ----------------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------------
`define TMR2_ADDR_CONTROL   8'hC8
`define TMR2_ADDR_RELOAD_LO 8'hCA
`define TMR2_ADDR_RELOAD_HI 8'hCB
`define TMR2_ADDR_COUNT_LO  8'hCC
`define TMR2_ADDR_COUNT_HI  8'hCD
// ----------------------------------------------------------------------
// control register fields
// ----------------------------------------------------------------------
`define TMR2_BIT_OVF        7
`define TMR2_BIT_EXTF       6
`define TMR2_BIT_RXCLK      5
`define TMR2_BIT_TXCLK      4
`define TMR2_BIT_TRIG_EN    3
`define TMR2_BIT_RUN        2
`define TMR2_BIT_CNT_SEL    1
`define TMR2_BIT_CAP_SEL    0
// ----------------------------------------------------------------------
// reset values and timing
// ----------------------------------------------------------------------
`define TMR2_RST_BYTE       8'h00
`define TMR2_RST_WORD       16'h0000
`define TMR2_TICK_CYCLES    1'b1
`endif

// ==== logic/tmr2_pkg.sv ====
// types shared by the capture/reload timer
// assumes tmr2_defines.svh sits in the include path
package tmr2_pkg;
   typedef struct packed {
      logic [7:0]  ctrl_r;
      logic [15:0] reload_r;
      logic [15:0] count_r;
      logic        prescale_r;
      logic [2:0]  cnt_pin_sync_r;
      logic [2:0]  trg_pin_sync_r;
      logic        cnt_pin_state_r;
      logic        trg_pin_state_r;
      logic [7:0]  rdata_r;
      logic        rx_tick_r;
      logic        tx_tick_r;
   } tmr2_state_t;
endpackage

// ==== testbench/tmr2_pin_model.sv ====
// far-side pin model: drives the count pin and the trigger pin, idle high
// assumes MCLK is the timer clock; pins move right after rising edges
`timescale 1ns/100ps
module tmr2_pin_model (
   // clock
   input  wire logic MCLK,
   // pins toward the timer
   output logic      COUNT_INPUT_PIN,
   output logic      EXTERNAL_TRIGGER_PIN
);
   // idle high so that reset release shows no falling edge
   initial begin
      COUNT_INPUT_PIN      = 1'b1;
      EXTERNAL_TRIGGER_PIN = 1'b1;
   end
   // 4 low, 4 high: wider than the 3-flop filter needs
   task automatic pulse(input bit trig, input int n);
      repeat (n) begin
         @(posedge MCLK);
         if (trig) EXTERNAL_TRIGGER_PIN <= 1'b0;
         else COUNT_INPUT_PIN <= 1'b0;
         repeat (4) @(posedge MCLK);
         COUNT_INPUT_PIN      <= 1'b1;
         EXTERNAL_TRIGGER_PIN <= 1'b1;
         repeat (4) @(posedge MCLK);
      end
   endtask
endmodule

// ==== testbench/timer2_capture_reload_counter_tb.sv ====
// self-checking bench for the capture/reload timer
// assumes tmr2_defines.svh in the include path and the pin model beside it
`timescale 1ns/100ps
`include "tmr2_defines.svh"
module timer2_capture_reload_counter_tb;
   import tmr2_pkg::*;
   logic       MCLK = 1'b0, RESET = 1'b1, WR = 1'b0, RD = 1'b0, RX_TICK, TX_TICK, CNT_PIN, TRG_PIN;
   logic [7:0] ADDR = 8'h00, WDATA = 8'h00, RDATA;
   int         mismatches = 0, tests_run = 0, rx_n = 0, tx_n = 0;
   // ----------------------------------------------------------------------
   // clock, reset, instances
   // ----------------------------------------------------------------------
   initial forever #10 MCLK = ~MCLK;
   tmr2_timer tmr2_timer_i (.MCLK(MCLK), .RESET(RESET), .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD),
      .RDATA(RDATA), .COUNT_INPUT_PIN(CNT_PIN), .EXTERNAL_TRIGGER_PIN(TRG_PIN),
      .SERIAL_RX_TICK(RX_TICK), .SERIAL_TX_TICK(TX_TICK));
   tmr2_pin_model tmr2_pin_model_i (.MCLK(MCLK), .COUNT_INPUT_PIN(CNT_PIN), .EXTERNAL_TRIGGER_PIN(TRG_PIN));
   // ticks are one cycle wide; counted on the falling edge, clear of the launching edge
   always @(negedge MCLK) begin
      if (RX_TICK === 1'b1) rx_n++;
      if (TX_TICK === 1'b1) tx_n++;
   end
   // ----------------------------------------------------------------------
   // bus and compare tasks
   // ----------------------------------------------------------------------
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      tests_run++;
      if (got !== exp) begin
         mismatches++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge MCLK);
      ADDR  <= a;
      WDATA <= d;
      WR    <= 1'b1;
      @(posedge MCLK);
      WR <= 1'b0;
   endtask
   // data stand only in the cycle after the strobe
   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      @(posedge MCLK);
      ADDR <= a;
      RD   <= 1'b1;
      @(posedge MCLK);
      RD <= 1'b0;
      #1 d = RDATA;
   endtask
   task automatic rchk(input logic [7:0] a, input logic [7:0] exp);
      logic [7:0] d;
      rd(a, d);
      chk(d, exp);
   endtask
   // write then read back with no idle cycle between the strobes
   task automatic wrchk(input logic [7:0] a, input logic [7:0] d);
      @(posedge MCLK);
      ADDR  <= a;
      WDATA <= d;
      WR    <= 1'b1;
      @(posedge MCLK);
      WR <= 1'b0;
      RD <= 1'b1;
      @(posedge MCLK);
      RD <= 1'b0;
      #1 chk(RDATA, d);
   endtask
   task automatic wcount(input logic [7:0] lo, input logic [7:0] hi);
      wr(`TMR2_ADDR_COUNT_LO, lo);
      wr(`TMR2_ADDR_COUNT_HI, hi);
   endtask
   // ----------------------------------------------------------------------
   // scenarios
   // ----------------------------------------------------------------------
   task automatic t_reset_regs();
      rchk(`TMR2_ADDR_CONTROL, 8'h00);
      rchk(`TMR2_ADDR_RELOAD_LO, 8'h00);
      rchk(`TMR2_ADDR_RELOAD_HI, 8'h00);
      rchk(`TMR2_ADDR_COUNT_LO, 8'h00);
      rchk(`TMR2_ADDR_COUNT_HI, 8'h00);
      rchk(8'hC9, 8'h00);
   endtask
   task automatic t_timer_rate();
      logic [7:0] d;
      logic [7:0] d2;
      wr(`TMR2_ADDR_CONTROL, 8'h04);
      repeat (19) @(posedge MCLK);
      wr(`TMR2_ADDR_CONTROL, 8'h00);
      rd(`TMR2_ADDR_COUNT_LO, d);
      // 21 running edges at one tick per two; the prescaler phase decides the last one
      chk({7'h00, d >= 8'h09 && d <= 8'h0B}, 8'h01);
      repeat (10) @(posedge MCLK);
      rd(`TMR2_ADDR_COUNT_LO, d2);
      chk(d2, d);
   endtask
   task automatic t_overflow();
      wrchk(`TMR2_ADDR_RELOAD_LO, 8'h34);
      wrchk(`TMR2_ADDR_RELOAD_HI, 8'h12);
      wcount(8'hFF, 8'hFF);
      wr(`TMR2_ADDR_CONTROL, 8'h04);
      repeat (6) @(posedge MCLK);
      // flag read while still running, so the write below cannot fake it
      rchk(`TMR2_ADDR_CONTROL, 8'h84);
      wr(`TMR2_ADDR_CONTROL, 8'h00);
      rchk(`TMR2_ADDR_CONTROL, 8'h00);
      rchk(`TMR2_ADDR_COUNT_HI, 8'h12);
      chk(8'(rx_n + tx_n), 8'h00);
   endtask
   task automatic t_counter_pin();
      wcount(8'h00, 8'h00);
      wr(`TMR2_ADDR_CONTROL, 8'h06);
      tmr2_pin_model_i.pulse(1'b0, 5);
      repeat (6) @(posedge MCLK);
      rchk(`TMR2_ADDR_COUNT_LO, 8'h05);
   endtask
   task automatic t_trigger();
      wcount(8'h5A, 8'hA5);
      wr(`TMR2_ADDR_CONTROL, 8'h09);
      tmr2_pin_model_i.pulse(1'b1, 1);
      repeat (6) @(posedge MCLK);
      rchk(`TMR2_ADDR_RELOAD_LO, 8'h5A);
      rchk(`TMR2_ADDR_RELOAD_HI, 8'hA5);
      rchk(`TMR2_ADDR_CONTROL, 8'h49);
      wcount(8'h00, 8'h00);
      wr(`TMR2_ADDR_CONTROL, 8'h08);
      tmr2_pin_model_i.pulse(1'b1, 1);
      repeat (6) @(posedge MCLK);
      rchk(`TMR2_ADDR_COUNT_LO, 8'h5A);
      rchk(`TMR2_ADDR_CONTROL, 8'h48);
   endtask
   task automatic t_serial();
      wcount(8'hFF, 8'hFF);
      wr(`TMR2_ADDR_CONTROL, 8'h3D);
      tmr2_pin_model_i.pulse(1'b1, 1);
      repeat (6) @(posedge MCLK);
      rchk(`TMR2_ADDR_COUNT_HI, 8'hA5);
      rchk(`TMR2_ADDR_CONTROL, 8'h3D);
      chk(8'(rx_n), 8'h01);
      chk(8'(tx_n), 8'h01);
   endtask
   // ----------------------------------------------------------------------
   // verdict, watchdog, main sequence
   // ----------------------------------------------------------------------
   task automatic conclude();
      $display("checks %0d mismatches %0d", tests_run, mismatches);
      if (mismatches == 0 && tests_run > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask
   // the run takes about 215 cycles; the 6000-cycle limit gives about 28x margin before giving up
   initial begin
      #120000 mismatches++;
      conclude();
   end
   initial begin
      repeat (4) @(posedge MCLK);
      RESET <= 1'b0;
      t_reset_regs();
      t_timer_rate();
      t_overflow();
      t_counter_pin();
      t_trigger();
      t_serial();
      conclude();
   end
endmodule
